/* File: rtl/cesc_cfg.svh */
`ifndef CESC_CFG_SVH
`define CESC_CFG_SVH

// Widths of the per-type cycle counts and of the state totals, and the number of cycle types
`define CESC_CNT_W          2
`define CESC_TOT_W          8
`define CESC_NUM_CYC        6

// States per cycle, by access location
`define CESC_SLEN_MEM       2'h2
`define CESC_SLEN_PERI_FAST 2'h2
`define CESC_SLEN_PERI_SLOW 2'h3
`define CESC_SLEN_INTERNAL  2'h1

// Cycle counts used by the decoder
`define CESC_FETCH_ONE      2'h1
`define CESC_FETCH_TWO      2'h2
`define CESC_FETCH_IMM8     2'h1
`define CESC_FETCH_IMM16    2'h2
`define CESC_FETCH_IMM32    2'h3
`define CESC_BIT_MEM_BYTES  2'h1
`define CESC_BR16_INTERNAL  2'h2

`endif

/* File: rtl/cesc_pkg.sv */
package cesc_pkg;

  typedef enum logic [3:0] {
    CESC_ADD_OP                 = 4'h0,
    CESC_ADD_SMALL_CONSTANT_OP  = 4'h1,
    CESC_ADD_WITH_CARRY_OP      = 4'h2,
    CESC_AND_OP                 = 4'h3,
    CESC_AND_CONDITION_CODE_OP  = 4'h4,
    CESC_BIT_AND_OP             = 4'h5,
    CESC_BRANCH_D8_OP           = 4'h6,
    CESC_BRANCH_D16_OP          = 4'h7
  } cesc_instr_e;

  typedef enum logic [1:0] {
    CESC_FORM_REG          = 2'h0,
    CESC_FORM_IMM          = 2'h1,
    CESC_FORM_REG_INDIRECT = 2'h2,
    CESC_FORM_ABS8         = 2'h3
  } cesc_form_e;

  typedef enum logic [1:0] {
    CESC_SIZE_BYTE = 2'h0,
    CESC_SIZE_WORD = 2'h1,
    CESC_SIZE_LONG = 2'h2
  } cesc_size_e;

  typedef enum logic [2:0] {
    CESC_CYC_FETCH       = 3'h0,
    CESC_CYC_BRANCH_READ = 3'h1,
    CESC_CYC_STACK       = 3'h2,
    CESC_CYC_BYTE_DATA   = 3'h3,
    CESC_CYC_WORD_DATA   = 3'h4,
    CESC_CYC_INTERNAL    = 3'h5
  } cesc_cyc_e;

  typedef enum logic {
    CESC_ST_IDLE = 1'b0,
    CESC_ST_RUN  = 1'b1
  } cesc_state_e;

  typedef struct packed {
    cesc_instr_e instr;
    cesc_form_e  form;
    cesc_size_e  size;
    logic        data_periph;
    logic        periph_slow;
  } cesc_req_s;

  // One 2-bit cycle count per cycle type, indexed by cesc_cyc_e
  typedef logic [5:0][1:0] cesc_cnt_t;

endpackage

/* File: rtl/cesc_state_timer.sv */
`timescale 1ns/10ps
`include "cesc_cfg.svh"

module cesc_state_timer (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   load,
  input  wire logic [`CESC_CNT_W-1:0] len,
  output logic                        active,
  output logic                        last
);
  logic [`CESC_CNT_W-1:0] cnt_reg;
  logic [`CESC_CNT_W-1:0] cnt_next;

  always_comb begin
    if (load) begin
      cnt_next = len;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - `CESC_CNT_W'(1);
    end else begin
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign active = (cnt_reg != '0);
  assign last   = (cnt_reg == `CESC_CNT_W'(1));
endmodule // cesc_state_timer

/* File: rtl/cesc_exec_counter.sv */
`timescale 1ns/10ps
`include "cesc_cfg.svh"

module cesc_exec_counter (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   req_valid,
  input  wire cesc_pkg::cesc_req_s    req,
  output logic                        req_ready,
  output logic                        busy,
  output cesc_pkg::cesc_cyc_e         cur_cycle,
  output logic                        state_strobe,
  output logic                        cycle_begin,
  output logic                        instr_done,
  output cesc_pkg::cesc_cnt_t         cycle_counts,
  output logic [`CESC_TOT_W-1:0]      total_states,
  output logic [`CESC_TOT_W-1:0]      elapsed_states
);
  import cesc_pkg::*;

  cesc_state_e            state_reg;
  cesc_state_e            state_next;
  cesc_cnt_t              cnt_reg;
  cesc_cnt_t              cnt_next;
  cesc_cnt_t              cnt_dec;
  cesc_cyc_e              cyc_reg;
  cesc_cyc_e              cyc_next;
  logic [`CESC_CNT_W-1:0] rem_reg;
  logic [`CESC_CNT_W-1:0] rem_next;
  logic                   periph_reg;
  logic                   periph_next;
  logic                   slow_reg;
  logic                   slow_next;
  logic [`CESC_TOT_W-1:0] total_reg;
  logic [`CESC_TOT_W-1:0] total_next;
  logic [`CESC_TOT_W-1:0] elapsed_reg;
  logic [`CESC_TOT_W-1:0] elapsed_next;
  logic                   begin_reg;
  logic                   begin_next;
  logic                   done_reg;
  logic                   done_next;
  logic                   tmr_load;
  logic [`CESC_CNT_W-1:0] tmr_len;
  logic                   tmr_active;
  logic                   tmr_last;
  logic                   accept;
  logic                   found;
  cesc_cyc_e              found_cyc;

  // State length of one cycle of a given type
  function automatic logic [`CESC_CNT_W-1:0] slen(input cesc_cyc_e c,
                                                  input logic periph,
                                                  input logic slow);
    case (c)
      CESC_CYC_FETCH:       slen = `CESC_SLEN_MEM;
      CESC_CYC_BRANCH_READ: slen = `CESC_SLEN_MEM;
      CESC_CYC_STACK:       slen = `CESC_SLEN_MEM;
      CESC_CYC_BYTE_DATA,
      CESC_CYC_WORD_DATA: begin
        if (!periph) begin
          slen = `CESC_SLEN_MEM;
        end else if (slow) begin
          slen = `CESC_SLEN_PERI_SLOW;
        end else begin
          slen = `CESC_SLEN_PERI_FAST;
        end
      end
      CESC_CYC_INTERNAL:    slen = `CESC_SLEN_INTERNAL;
      default:              slen = `CESC_SLEN_MEM;
    endcase
  endfunction

  // Cycle counts per instruction class and operand form
  always_comb begin
    cnt_dec = '0;
    cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_ONE;
    case (req.instr)
      CESC_ADD_OP,
      CESC_AND_OP: begin
        if (req.form == CESC_FORM_IMM) begin
          case (req.size)
            CESC_SIZE_BYTE: cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_IMM8;
            CESC_SIZE_WORD: cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_IMM16;
            CESC_SIZE_LONG: cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_IMM32;
            default:        cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_ONE;
          endcase
        end else if (req.instr == CESC_AND_OP &&
                     req.size == CESC_SIZE_LONG) begin
          cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_TWO;
        end else begin
          cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_ONE;
        end
      end
      CESC_ADD_SMALL_CONSTANT_OP,
      CESC_ADD_WITH_CARRY_OP,
      CESC_AND_CONDITION_CODE_OP: begin
        cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_ONE;
      end
      CESC_BIT_AND_OP: begin
        if (req.form == CESC_FORM_REG_INDIRECT ||
            req.form == CESC_FORM_ABS8) begin
          cnt_dec[CESC_CYC_FETCH]     = `CESC_FETCH_TWO;
          cnt_dec[CESC_CYC_BYTE_DATA] = `CESC_BIT_MEM_BYTES;
        end else begin
          cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_ONE;
        end
      end
      CESC_BRANCH_D8_OP: begin
        cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_TWO;
      end
      CESC_BRANCH_D16_OP: begin
        cnt_dec[CESC_CYC_FETCH]    = `CESC_FETCH_TWO;
        cnt_dec[CESC_CYC_INTERNAL] = `CESC_BR16_INTERNAL;
      end
      default: begin
        cnt_dec[CESC_CYC_FETCH] = `CESC_FETCH_ONE;
      end
    endcase
  end

  assign accept    = (state_reg == CESC_ST_IDLE) && req_valid;
  assign req_ready = (state_reg == CESC_ST_IDLE);

  // Next cycle type with a nonzero count: from the first type on accept,
  // otherwise strictly after the current one. Skipping here avoids a
  // dead clock for empty types.
  always_comb begin
    cesc_cnt_t c;
    int        lo;
    c         = accept ? cnt_dec : cnt_reg;
    lo        = accept ? 0 : int'(cyc_reg) + 1;
    found     = 1'b0;
    found_cyc = CESC_CYC_FETCH;
    for (int t = `CESC_NUM_CYC - 1; t >= 0; t--) begin
      if (t >= lo && c[t] != '0) begin
        found     = 1'b1;
        found_cyc = cesc_cyc_e'(3'(t));
      end
    end
  end

  always_comb begin
    logic [`CESC_TOT_W-1:0] sum;
    sum          = '0;
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    cyc_next     = cyc_reg;
    rem_next     = rem_reg;
    periph_next  = periph_reg;
    slow_next    = slow_reg;
    total_next   = total_reg;
    elapsed_next = elapsed_reg;
    begin_next   = 1'b0;
    done_next    = 1'b0;
    tmr_load     = 1'b0;
    tmr_len      = slen(cyc_reg, periph_reg, slow_reg);
    case (state_reg)
      CESC_ST_IDLE: begin
        if (accept) begin
          for (int t = 0; t < `CESC_NUM_CYC; t++) begin
            sum = sum + `CESC_TOT_W'(cnt_dec[t]) *
                  `CESC_TOT_W'(slen(cesc_cyc_e'(3'(t)), req.data_periph,
                                    req.periph_slow));
          end
          cnt_next     = cnt_dec;
          periph_next  = req.data_periph;
          slow_next    = req.periph_slow;
          total_next   = sum;
          elapsed_next = '0;
          if (found) begin
            state_next = CESC_ST_RUN;
            cyc_next   = found_cyc;
            rem_next   = cnt_dec[found_cyc];
            tmr_load   = 1'b1;
            tmr_len    = slen(found_cyc, req.data_periph, req.periph_slow);
            begin_next = 1'b1;
          end else begin
            done_next = 1'b1;
          end
        end
      end
      CESC_ST_RUN: begin
        if (tmr_active) begin
          elapsed_next = elapsed_reg + `CESC_TOT_W'(1);
        end
        if (tmr_last) begin
          if (rem_reg > `CESC_CNT_W'(1)) begin
            rem_next   = rem_reg - `CESC_CNT_W'(1);
            tmr_load   = 1'b1;
            begin_next = 1'b1;
          end else if (found) begin
            cyc_next   = found_cyc;
            rem_next   = cnt_reg[found_cyc];
            tmr_load   = 1'b1;
            tmr_len    = slen(found_cyc, periph_reg, slow_reg);
            begin_next = 1'b1;
          end else begin
            state_next = CESC_ST_IDLE;
            rem_next   = '0;
            done_next  = 1'b1;
          end
        end
      end
      default: begin
        state_next = CESC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg   <= CESC_ST_IDLE;
      cnt_reg     <= '0;
      cyc_reg     <= CESC_CYC_FETCH;
      rem_reg     <= '0;
      periph_reg  <= 1'b0;
      slow_reg    <= 1'b0;
      total_reg   <= '0;
      elapsed_reg <= '0;
      begin_reg   <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      cyc_reg     <= cyc_next;
      rem_reg     <= rem_next;
      periph_reg  <= periph_next;
      slow_reg    <= slow_next;
      total_reg   <= total_next;
      elapsed_reg <= elapsed_next;
      begin_reg   <= begin_next;
      done_reg    <= done_next;
    end
  end

  cesc_state_timer u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (tmr_load),
    .len     (tmr_len),
    .active  (tmr_active),
    .last    (tmr_last)
  );

  assign busy           = (state_reg == CESC_ST_RUN);
  assign cur_cycle      = cyc_reg;
  assign state_strobe   = tmr_active;
  assign cycle_begin    = begin_reg;
  assign instr_done     = done_reg;
  assign cycle_counts   = cnt_reg;
  assign total_states   = total_reg;
  assign elapsed_states = elapsed_reg;
endmodule // cesc_exec_counter

/* File: sim/cesc_exec_counter_properties.sv */
`timescale 1ns/10ps
module cesc_exec_counter_chk
  import cesc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        req_valid,
  input wire cesc_req_s   req,
  input wire logic        req_ready,
  input wire logic        busy,
  input wire cesc_cyc_e   cur_cycle,
  input wire logic        state_strobe,
  input wire logic        cycle_begin,
  input wire logic        instr_done,
  input wire cesc_cnt_t   cycle_counts,
  input wire logic [7:0]  total_states,
  input wire logic [7:0]  elapsed_states
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic acc;
  logic bit_mem;
  logic imm_add;
  logic and_long;
  logic one_fetch;
  assign acc = req_valid && req_ready;
  assign bit_mem = acc && req.instr == CESC_BIT_AND_OP &&
                   req.form inside {CESC_FORM_REG_INDIRECT, CESC_FORM_ABS8};
  assign imm_add = acc && req.form == CESC_FORM_IMM &&
                   req.instr inside {CESC_ADD_OP, CESC_AND_OP};
  assign and_long = acc && req.instr == CESC_AND_OP &&
                    req.form == CESC_FORM_REG && req.size == CESC_SIZE_LONG;
  assign one_fetch = acc && req.instr inside {CESC_ADD_SMALL_CONSTANT_OP,
                     CESC_ADD_WITH_CARRY_OP, CESC_AND_CONDITION_CODE_OP};
  sequence s_short_run;
    (!instr_done) [*4] ##1 instr_done;
  endsequence
  sequence s_second_state;
    !cycle_begin && state_strobe;
  endsequence
  chk_done_sum: assert property (
    instr_done |-> elapsed_states == total_states)
    else $error("elapsed count differs from total at done");
  chk_fetch_len: assert property (
    cycle_begin && cur_cycle == CESC_CYC_FETCH |=> s_second_state)
    else $error("fetch cycle shorter than two states");
  chk_periph_len: assert property (
    bit_mem |=> total_states ==
    ($past(req.data_periph && req.periph_slow) ? 8'h07 : 8'h06))
    else $error("data cycle length wrong for location");
  chk_imm_fetch: assert property (
    imm_add |=> cycle_counts[0] == $past(req.size) + 2'h1)
    else $error("immediate fetch count wrong");
  chk_and_long: assert property (
    and_long |=> cycle_counts[0] == 2'h2)
    else $error("long register and fetch count wrong");
  chk_bit_mem: assert property (
    bit_mem |=> cycle_counts[0] == 2'h2 && cycle_counts[3] == 2'h1)
    else $error("bit-and memory counts wrong");
  chk_short_branch: assert property (
    acc && req.instr == CESC_BRANCH_D8_OP |=> s_short_run)
    else $error("short branch did not finish after four states");
  chk_one_fetch: assert property (
    one_fetch |=> total_states == 8'h02)
    else $error("single fetch instruction total wrong");
  chk_done_ready: assert property (
    instr_done |-> req_ready && !busy && !state_strobe)
    else $error("done while still sequencing");
  chk_accept_begin: assert property (
    acc |=> busy && cycle_begin && cur_cycle == CESC_CYC_FETCH)
    else $error("instruction did not start with a fetch");
endmodule // cesc_exec_counter_chk

bind cesc_exec_counter cesc_exec_counter_chk u_chk (
  .clk            (clk),
  .reset_n        (reset_n),
  .req_valid      (req_valid),
  .req            (req),
  .req_ready      (req_ready),
  .busy           (busy),
  .cur_cycle      (cur_cycle),
  .state_strobe   (state_strobe),
  .cycle_begin    (cycle_begin),
  .instr_done     (instr_done),
  .cycle_counts   (cycle_counts),
  .total_states   (total_states),
  .elapsed_states (elapsed_states)
);

/* File: sim/cesc_periph_model.sv */
`timescale 1ns/10ps
module cesc_periph_model (
  input  wire logic [7:0] addr,
  output logic            data_periph,
  output logic            periph_slow
);
  // Top quarter of the map holds peripherals; half of them need the
  // longer access, so the addressed module decides the length
  assign data_periph = addr[7:6] == 2'b11;
  assign periph_slow = data_periph && addr[5];
endmodule // cesc_periph_model

/* File: sim/test_cesc_exec_counter.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %0h got %0h", n, e, g); error_cnt++; end end
module test_cesc_exec_counter;
  import cesc_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       req_valid = 1'b0;
  cesc_req_s  req = '0;
  logic       req_ready, busy, state_strobe, cycle_begin, instr_done;
  cesc_cyc_e  cur_cycle;
  cesc_cnt_t  cycle_counts;
  logic [7:0] total_states, elapsed_states, t_exp;
  logic [7:0] addr = 8'h00;
  logic       data_periph, periph_slow;
  int         error_cnt = 0, num_checks = 0, cyc = 0, seed = 6087, a_exp;
  logic [7:0] exp_tot[$];
  int         exp_at[$];
  always #2 clk = ~clk;
  cesc_exec_counter dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .busy(busy), .cur_cycle(cur_cycle),
    .state_strobe(state_strobe), .cycle_begin(cycle_begin),
    .instr_done(instr_done), .cycle_counts(cycle_counts),
    .total_states(total_states), .elapsed_states(elapsed_states));
  cesc_periph_model far (.addr(addr), .data_periph(data_periph),
    .periph_slow(periph_slow));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  function automatic logic [7:0] expect_total(cesc_req_s r);
    logic [7:0] i, l, n, sl;
    i = 8'h01;
    l = 8'h00;
    n = 8'h00;
    sl = (r.data_periph && r.periph_slow) ? 8'h03 : 8'h02;
    case (r.instr)
      CESC_ADD_OP, CESC_AND_OP: begin
        if (r.form == CESC_FORM_IMM) begin
          i = 8'(r.size) + 8'h01;
        end else if (r.instr == CESC_AND_OP && r.size == CESC_SIZE_LONG) begin
          i = 8'h02;
        end
      end
      CESC_BIT_AND_OP: begin
        if (r.form != CESC_FORM_REG) begin
          i = 8'h02;
          l = 8'h01;
        end
      end
      CESC_BRANCH_D8_OP: i = 8'h02;
      CESC_BRANCH_D16_OP: begin
        i = 8'h02;
        n = 8'h02;
      end
      default: i = 8'h01;
    endcase
    return 8'(2 * i + l * sl + n);
  endfunction
  function automatic bit combo_ok(int k, int f);
    return (k == 0 || k == 3) ? f < 2 : (k == 5) ? f != 1 : f == 0;
  endfunction
  // Valid stays up while busy, with the old request for one cycle and then the next one, so refusal is exercised
  task automatic send(int k, int f, int s, logic [7:0] a);
    cesc_req_s r;
    addr = a;
    #0.1;
    r = '{cesc_instr_e'(k), cesc_form_e'(f), cesc_size_e'(s), data_periph,
          periph_slow};
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    exp_tot.push_back(expect_total(r));
    // Done pulse stands in the cycle after the last state is spent
    exp_at.push_back(cyc + int'(expect_total(r)) + 1);
    @(posedge clk);
  endtask
  always @(negedge clk) if (instr_done === 1'b1) begin
    if (exp_tot.size() == 0) begin
      `CHK("unrequested done", 1'b0, 1'b1)
    end else begin
      t_exp = exp_tot.pop_front();
      a_exp = exp_at.pop_front();
      `CHK("elapsed_states", t_exp, elapsed_states)
      `CHK("total_states", t_exp, total_states)
      `CHK("done cycle", a_exp, cyc)
    end
  end
  initial begin
    int k, f, s;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    for (k = 0; k < 8; k++) for (f = 0; f < 4; f++) for (s = 0; s < 3; s++)
      // Size 0 lands in the peripheral area; form bit 0 clear picks the slow one
      if (combo_ok(k, f)) send(k, f, s, {s[1:0], f[0], 5'h00} ^ 8'he0);
    $display("test directed done");
    repeat (150) begin
      k = {$random(seed)} % 8;
      f = {$random(seed)} % 4;
      s = {$random(seed)} % 3;
      if (combo_ok(k, f)) send(k, f, s, 8'($random(seed)));
      if ({$random(seed)} % 4 == 0) begin
        @(posedge clk);
        req_valid <= 1'b0;
      end
    end
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (20) @(negedge clk);
    `CHK("pending results", 0, exp_tot.size())
    $display("test random done");
    give_verdict();
  end
endmodule // test_cesc_exec_counter
